// ===== include/fspd_map.svh
`ifndef FSPD_MAP_SVH
`define FSPD_MAP_SVH

// Instruction codes
`define FSPD_OP_SUSPEND     8'h75
`define FSPD_OP_RESUME      8'h7A
`define FSPD_OP_PD_ENTER    8'hB9
`define FSPD_OP_PD_EXIT     8'hAB
`define FSPD_OP_READ_STATUS 8'h05

// Power-down / polling parameter dword and its fields
`define FSPD_PARAM_DWORD    32'h5CD5A2F7
`define FSPD_PARAM_PD_SUP   31
`define FSPD_PARAM_ENTER    30:23
`define FSPD_PARAM_EXIT     22:15
`define FSPD_PARAM_WAKE_UNIT 14:13
`define FSPD_PARAM_WAKE_CNT 12:8
`define FSPD_PARAM_POLL     3:2
`define FSPD_PARAM_RSV_HI   7:4
`define FSPD_PARAM_RSV_LO   1:0
`define FSPD_RSV_HI_VAL     4'hF
`define FSPD_RSV_LO_VAL     2'h3
// Wake-up unit 1 us with count 2, i.e. three microseconds; legacy status polling
`define FSPD_WAKE_UNIT_VAL  2'h1
`define FSPD_WAKE_CNT_VAL   5'h02
`define FSPD_POLL_VAL       2'h1

// Status byte field
`define FSPD_STAT_BUSY      0

// Wake-up delay: (count + 1) * 1 us
`define FSPD_WAKE_NS        3000
`define FSPD_CLK_NS         100
`define FSPD_WAKE_CYC       ((`FSPD_WAKE_NS + `FSPD_CLK_NS - 1) / `FSPD_CLK_NS)

`endif

// ===== include/fspd_pkg.sv
package fspd_pkg;
  typedef enum logic [2:0] {
    FSPD_IDLE      = 3'h0,
    FSPD_PROG      = 3'h1,
    FSPD_PROG_SUSP = 3'h3,
    FSPD_ERASE     = 3'h2,
    FSPD_ERASE_SUSP= 3'h6,
    FSPD_PD        = 3'h4,
    FSPD_WAKE      = 3'h5
  } fspd_state_t;
endpackage

// ===== include/fspd_rx_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fspd_rx_if;
  logic       byte_vld;
  logic [7:0] byte_val;
  logic       first;
  logic [7:0] tx_byte;
  logic       tx_load;
  modport rx (output byte_vld, output byte_val, output first, input tx_byte, input tx_load);
  modport core (input byte_vld, input byte_val, input first, output tx_byte, output tx_load);
endinterface
`default_nettype wire

// ===== core/fspd_shift.sv
`timescale 1ns/1ps
`default_nettype none
// Serial shifter: SPI mode 0, sampled synchronously to clk_sys_i.
module fspd_shift (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  input  wire logic sclk_i,
  input  wire logic cs_n_i,
  input  wire logic mosi_i,
  output logic      miso_o,
  fspd_rx_if.rx     rx
);
  logic       sclk_d;
  logic [2:0] cnt;
  logic [7:0] sh;
  logic [7:0] tx;
  logic       first;
  logic [2:0] next_cnt;
  logic [7:0] next_sh;
  logic [7:0] next_tx;
  logic       next_first;
  logic       next_miso;
  logic       vld;
  logic       rise;
  logic       fall;

  assign rise = sclk_i & ~sclk_d;
  assign fall = ~sclk_i & sclk_d;

  always_comb begin
    next_cnt   = cnt;
    next_sh    = sh;
    next_tx    = tx;
    next_first = first;
    next_miso  = miso_o;
    vld        = 1'b0;
    if (cs_n_i) begin
      next_cnt   = 3'h0;
      next_first = 1'b1;
      next_tx    = 8'h00;
      next_miso  = 1'b0;
    end else begin
      if (rx.tx_load) begin
        next_tx = rx.tx_byte;
      end else if (fall) begin
        // Mode 0: each fall presents the next bit, so bit 7 leads the reply byte
        next_miso = tx[7];
        next_tx   = {tx[6:0], 1'b0};
      end
      if (rise) begin
        next_sh  = {sh[6:0], mosi_i};
        next_cnt = cnt + 3'h1;
        if (cnt == 3'h7) begin
          vld        = 1'b1;
          next_first = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sclk_d <= 1'b0;
      cnt    <= 3'h0;
      sh     <= 8'h00;
      tx     <= 8'h00;
      first  <= 1'b1;
      miso_o <= 1'b0;
    end else if (ce_i) begin
      sclk_d <= sclk_i;
      cnt    <= next_cnt;
      sh     <= next_sh;
      tx     <= next_tx;
      first  <= next_first;
      miso_o <= next_miso;
    end
  end

  assign rx.byte_vld = vld & ce_i;
  assign rx.byte_val = {sh[6:0], mosi_i};
  assign rx.first    = first;
endmodule
`default_nettype wire

// ===== core/fspd_core.sv
`include "fspd_map.svh"
`timescale 1ns/1ps
`default_nettype none
module fspd_core
  import fspd_pkg::*;
#(
  parameter int WAKE_CYC = `FSPD_WAKE_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic        mosi_i,
  input  wire logic        prog_start_i,
  input  wire logic        erase_start_i,
  input  wire logic        op_done_i,
  output logic             miso_o,
  output logic             busy_flag_bit_o,
  output logic             suspend_o,
  output logic             deep_pd_o,
  output logic             ready_o,
  output logic [31:0]      param_dword_o
);
  // Bytes and the reply path between shifter and decoder
  fspd_rx_if rx ();

  // Command state and wake-up timer
  logic        miso;
  fspd_state_t state;
  fspd_state_t next_state;
  logic [7:0]  wake;
  logic [7:0]  next_wake;
  logic [7:0]  tx_byte;
  logic        tx_load;
  logic [31:0] param;
  logic        status_busy;
  // Next values of the registered outputs
  logic        next_busy;
  logic        next_suspend;
  logic        next_deep_pd;
  logic        next_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Serial framing; only the first byte after chip select is an opcode
  fspd_shift u_shift (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .sclk_i    (sclk_i),
    .cs_n_i    (cs_n_i),
    .mosi_i    (mosi_i),
    .miso_o    (miso),
    .rx        (rx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers
  // True in the one cycle in which a whole opcode byte has arrived and matches op
  function automatic logic is_op(input logic [7:0] b, input logic [7:0] op);
    return rx.byte_vld && rx.first && (b == op);
  endfunction

  // An operation runs only while neither suspended nor waking
  function automatic logic is_running(input fspd_state_t s);
    return (s == FSPD_PROG) || (s == FSPD_ERASE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Parameter dword; opcode fields reuse the decoder's codes so the two cannot drift
  always_comb begin
    param                        = `FSPD_PARAM_DWORD;
    param[`FSPD_PARAM_PD_SUP]    = 1'b0;
    param[`FSPD_PARAM_ENTER]     = `FSPD_OP_PD_ENTER;
    param[`FSPD_PARAM_EXIT]      = `FSPD_OP_PD_EXIT;
    param[`FSPD_PARAM_WAKE_UNIT] = `FSPD_WAKE_UNIT_VAL;
    param[`FSPD_PARAM_WAKE_CNT]  = `FSPD_WAKE_CNT_VAL;
    param[`FSPD_PARAM_POLL]      = `FSPD_POLL_VAL;
    param[`FSPD_PARAM_RSV_HI]    = `FSPD_RSV_HI_VAL;
    param[`FSPD_PARAM_RSV_LO]    = `FSPD_RSV_LO_VAL;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command state
  // Opcodes that do not fit the current state are dropped silently
  always_comb begin
    next_state = state;
    next_wake  = wake;
    case (state)
      FSPD_IDLE: begin
        // Power-down only from idle; program wins when both starts arrive together
        if (is_op(rx.byte_val, `FSPD_OP_PD_ENTER)) begin
          next_state = FSPD_PD;
        end else if (prog_start_i) begin
          next_state = FSPD_PROG;
        end else if (erase_start_i) begin
          next_state = FSPD_ERASE;
        end
      end

      FSPD_PROG: begin
        // Completion is only seen while running; a suspended operation waits for resume
        if (is_op(rx.byte_val, `FSPD_OP_SUSPEND)) begin
          next_state = FSPD_PROG_SUSP;
        end else if (op_done_i) begin
          next_state = FSPD_IDLE;
        end
      end

      FSPD_PROG_SUSP: begin
        // Only resume leaves this state
        if (is_op(rx.byte_val, `FSPD_OP_RESUME)) begin
          next_state = FSPD_PROG;
        end
      end

      FSPD_ERASE: begin
        // Erase mirrors program, with a suspended state of its own
        if (is_op(rx.byte_val, `FSPD_OP_SUSPEND)) begin
          next_state = FSPD_ERASE_SUSP;
        end else if (op_done_i) begin
          next_state = FSPD_IDLE;
        end
      end

      FSPD_ERASE_SUSP: begin
        // Same resume code as for program; the state tells the two apart
        if (is_op(rx.byte_val, `FSPD_OP_RESUME)) begin
          next_state = FSPD_ERASE;
        end
      end

      FSPD_PD: begin
        // Everything but the exit opcode is ignored, including status reads
        // The 8-bit timer limits WAKE_CYC to 255
        if (is_op(rx.byte_val, `FSPD_OP_PD_EXIT)) begin
          next_state = FSPD_WAKE;
          next_wake  = WAKE_CYC[7:0];
        end
      end

      FSPD_WAKE: begin
        // Host is expected to hold off; we just time the recovery
        if (wake <= 8'h01) begin
          next_state = FSPD_IDLE;
          next_wake  = 8'h00;
        end else begin
          next_wake = wake - 8'h01;
        end
      end

      default: begin
        next_state = FSPD_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status byte, loaded into the shifter as the read-status opcode completes
  always_comb begin
    // Waking reports busy too, so a host that polls rather than times stays safe
    status_busy = is_running(state) || (state == FSPD_WAKE);
    tx_byte     = 8'h00;
    tx_load     = 1'b0;
    if (state != FSPD_PD && is_op(rx.byte_val, `FSPD_OP_READ_STATUS)) begin
      tx_load                  = 1'b1;
      tx_byte[`FSPD_STAT_BUSY] = status_busy;
    end
  end

  assign rx.tx_byte = tx_byte;
  assign rx.tx_load = tx_load;

  ////////////////////////////////////////////////////////////////////////////
  // Output levels follow the next state so that they change together with it
  always_comb begin
    next_busy    = is_running(next_state);
    next_suspend = (next_state == FSPD_PROG_SUSP) || (next_state == FSPD_ERASE_SUSP);
    next_deep_pd = (next_state == FSPD_PD);
    next_ready   = (next_state != FSPD_PD) && (next_state != FSPD_WAKE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; a low clock enable freezes everything, the serial output included
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state           <= FSPD_IDLE;
      wake            <= 8'h00;
      miso_o          <= 1'b0;
      busy_flag_bit_o <= 1'b0;
      suspend_o       <= 1'b0;
      deep_pd_o       <= 1'b0;
      ready_o         <= 1'b1;
      // Reads zero until the first enabled edge after reset
      param_dword_o   <= 32'h00000000;
    end else if (ce_i) begin
      state           <= next_state;
      wake            <= next_wake;
      miso_o          <= miso;
      busy_flag_bit_o <= next_busy;
      suspend_o       <= next_suspend;
      deep_pd_o       <= next_deep_pd;
      ready_o         <= next_ready;
      param_dword_o   <= param;
    end
  end
endmodule
`default_nettype wire

// ===== test/fspd_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module fspd_mon #(
  parameter int WAKE_CYC = 30
) (
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic        ce_i,
  input wire logic        sclk_i,
  input wire logic        cs_n_i,
  input wire logic        mosi_i,
  input wire logic        prog_start_i,
  input wire logic        erase_start_i,
  input wire logic        op_done_i,
  input wire logic        miso_o,
  input wire logic        busy_flag_bit_o,
  input wire logic        suspend_o,
  input wire logic        deep_pd_o,
  input wire logic        ready_o,
  input wire logic [31:0] param_dword_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Cycles spent waking; bounded so a stuck wake delay shows up
  logic [7:0] wcnt;
  always_ff @(posedge clk_sys_i) wcnt <= (ready_o || deep_pd_o) ? 8'h00 : wcnt + 8'h01;
  ////////////////////////////////////////
  a_param_value: assert property ($past(rst_n_i) |-> param_dword_o == 32'h5CD5A2F7)
    else $error("parameter dword wrong");
  a_pd_support: assert property (param_dword_o != 32'h0 |-> !param_dword_o[31])
    else $error("power-down support bit set");
  a_rsv_bits: assert property (param_dword_o != 32'h0 |->
    param_dword_o[7:4] == 4'hF && param_dword_o[1:0] == 2'h3)
    else $error("reserved bits not ones");
  a_pd_not_ready: assert property (deep_pd_o |-> !ready_o && !busy_flag_bit_o)
    else $error("ready or busy in power-down");
  a_wake_hold: assert property ($fell(deep_pd_o) |-> !ready_o [*2])
    else $error("ready too soon after wake");
  a_wake_bound: assert property (wcnt <= WAKE_CYC + 2)
    else $error("wake delay too long");
  a_susp_cause: assert property ($rose(suspend_o) |->
    $past(busy_flag_bit_o) && !busy_flag_bit_o)
    else $error("suspend without running op");
  a_resume_busy: assert property ($fell(suspend_o) |-> busy_flag_bit_o)
    else $error("resume did not restart op");
  a_pd_entry: assert property ($rose(deep_pd_o) |->
    !$past(busy_flag_bit_o) && !$past(suspend_o))
    else $error("power-down entered while not idle");
  c_pd: cover property ($rose(deep_pd_o));
  c_susp: cover property ($rose(suspend_o));
  c_wake: cover property ($rose(ready_o));
endmodule
bind fspd_core fspd_mon #(.WAKE_CYC(WAKE_CYC)) mon (.*);
`default_nettype wire

// ===== test/fspd_host.sv
`timescale 1ns/1ps
`default_nettype none
module fspd_host (
  input  wire logic clk_sys_i,
  input  wire logic miso_i,
  output var logic  sclk_o,
  output var logic  cs_n_o,
  output var logic  mosi_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Opcode then a second byte; st is the OR of bits read back, since only bit 0 may be set
  task automatic xfer(input logic [7:0] op, output logic st);
    st = 1'b0;
    @(posedge clk_sys_i);
    #1 cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_o = (i > 7) ? op[i-8] : ~mosi_o;
      repeat (2) @(posedge clk_sys_i);
      #1 sclk_o = 1'b1;
      if (i < 8) st = st | miso_i;
      repeat (2) @(posedge clk_sys_i);
      #1 sclk_o = 1'b0;
    end
    repeat (2) @(posedge clk_sys_i);
    #1 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    repeat (4) @(posedge clk_sys_i);
  endtask
  task automatic wake_wait(input int cyc);
    repeat (cyc) @(posedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

// ===== test/flash_suspend_powerdown_cmds_bench.sv
`timescale 1ns/1ps
`default_nettype none
module flash_suspend_powerdown_cmds_bench;
  logic        clk_sys_i, rst_n_i, ce, prog, erase, done, sclk, cs_n, mosi;
  logic        miso, busy, susp, pd, rdy, st;
  logic [31:0] param;
  int          miscompares = 0, num_checks = 0, cyc = 0;
  fspd_core #(.WAKE_CYC(3)) dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .prog_start_i(prog),
    .erase_start_i(erase), .op_done_i(done), .miso_o(miso), .busy_flag_bit_o(busy),
    .suspend_o(susp), .deep_pd_o(pd), .ready_o(rdy), .param_dword_o(param));
  fspd_host host (.clk_sys_i(clk_sys_i), .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n),
    .mosi_o(mosi));
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(posedge clk_sys_i);
    #1 s = 1'b1;
    @(posedge clk_sys_i);
    #1 s = 1'b0;
    repeat (2) @(posedge clk_sys_i);
  endtask
  task automatic cmd(input logic [7:0] op);
    host.xfer(op, st);
  endtask
  ////////////////////////////////////////
  task automatic t_param();
    chk(param, 32'h5CD5A2F7);
    chk(param[31], 0);
    chk({param[7:4], param[1:0]}, 32'h3F);
  endtask
  // Misplaced opcodes are sent first, so a decoder that ignores state fails here
  task automatic t_prog();
    pulse(prog);
    cmd(8'h7A);
    chk({busy, susp}, 2);
    cmd(8'hB9);
    chk(pd, 0);
    cmd(8'h05);
    chk(st, 1);
    cmd(8'h75);
    chk({busy, susp}, 1);
    cmd(8'h05);
    chk(st, 0);
    cmd(8'h7A);
    chk({busy, susp}, 2);
    pulse(done);
    chk(busy, 0);
  endtask
  task automatic t_erase();
    pulse(erase);
    cmd(8'h75);
    chk({busy, susp}, 1);
    cmd(8'h7A);
    chk({busy, susp}, 2);
    pulse(done);
    chk(busy, 0);
  endtask
  task automatic t_pd();
    cmd(8'hB9);
    chk({pd, rdy}, 2);
    cmd(8'h7A);
    chk({pd, busy}, 2);
    cmd(8'hAB);
    host.wake_wait(3);
    chk({pd, rdy}, 1);
    cmd(8'hB9);
    chk(pd, 1);
    cmd(8'hAB);
    chk(pd, 0);
  endtask
  // A low clock enable must hold a running program through a completion pulse
  task automatic t_ce();
    pulse(prog);
    #1 ce = 1'b0;
    pulse(done);
    chk(busy, 1);
    #1 ce = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    chk(busy, 1);
    pulse(done);
    chk(busy, 0);
  endtask
  initial begin
    rst_n_i = 1'b0;
    ce = 1'b1;
    prog = 1'b0;
    erase = 1'b0;
    done = 1'b0;
    repeat (8) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    t_param();
    t_prog();
    t_erase();
    t_pd();
    t_ce();
    finish_test();
  end
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end
endmodule
`default_nettype wire
